// ### design/dcl_dac_control.sv
// control logic of an 8-bit resistor-string converter: register file,
// enable and sleep sequencing, conversion start pulses
// assumes a zero-wait AHB-Lite master and sleep levels on the same clock
//
// Functional notes
// - control bit 0 written 1 turns converter on, 0 turns it off
// - while running, each code register write starts a conversion at once
// - while disabled, code write only stores; converted when enable is set
// - running converter output always offered to comparator and sampler
// - control bit 6 powers the output buffer and routes output to pin
// - keep-running bit 7 set keeps converter and buffer on in standby
// - keep-running clear: standby halts conversion, powers converter down
// - leaving standby re-powers converter, buffer if set, after start-up time
// - power-down sleep always turns converter and buffer off
// - code register holds 8-bit code spanning ground to reference
// - processor debug halt does not affect converter operation
// - only the first instance drives the pin path
//
// Local design decision: the AHB-Lite register port.

`timescale 1ns/1ps

module dcl_dac_control
    import dcl_pkg::*;
#(
    parameter int unsigned INSTANCE_NUM = 0
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic standby_sleep,
    input wire logic powerdown_sleep,
    output dcl_analog_t analog,
    output logic startup_busy
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // one-hot select: bit 0 control, bit 1 code, zero for unmapped
    function automatic logic [1:0] dcl_decode(input logic [31:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        if (addr[31:8] == 24'h000000 && addr[1:0] == 2'h0)
        begin
            if (addr[7:2] == DCL_CTRL_IDX)
                sel = 2'h1;
            else if (addr[7:2] == DCL_CODE_IDX)
                sel = 2'h2;
        end
        return sel;
    endfunction

    // ------------------------------------------------------------------
    // bus slave and register file
    // ------------------------------------------------------------------
    logic wr_ctrl_q, wr_ctrl_d;
    logic wr_code_q, wr_code_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic hready_q;
    logic hresp_q;
    dcl_ctrl_t ctrl_q, ctrl_d;
    logic [7:0] code_q, code_d;
    logic acc;
    logic [1:0] sel;

    // address phase captured, write data applied in the data phase
    always_comb
    begin
        acc = hsel && hready && (htrans == DCL_HTRANS_NONSEQ);
        sel = dcl_decode(haddr);
        // sub-word writes are ignored, not merged
        wr_ctrl_d = acc && hwrite && (hsize == DCL_HSIZE_WORD) && sel[0];
        wr_code_d = acc && hwrite && (hsize == DCL_HSIZE_WORD) && sel[1];
        ctrl_d = ctrl_q;
        code_d = code_q;
        if (wr_ctrl_q)
            ctrl_d = dcl_ctrl_t'(hwdata[7:0] & DCL_CTRL_WMASK);
        if (wr_code_q)
            code_d = hwdata[7:0];
        // read forwards next values so a read right after a write is fresh
        hrdata_d = hrdata_q;
        if (acc && !hwrite)
        begin
            hrdata_d = 32'h00000000;
            if (sel[0])
                hrdata_d = {24'h000000, ctrl_d};
            else if (sel[1])
                hrdata_d = {24'h000000, code_d};
        end
    end

    // registers of the bus slave; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ctrl_q <= 1'b0;
            wr_code_q <= 1'b0;
            hrdata_q <= 32'h00000000;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
            ctrl_q <= dcl_ctrl_t'(DCL_CTRL_RST);
            code_q <= DCL_CODE_RST;
        end
        else if (ce)
        begin
            wr_ctrl_q <= wr_ctrl_d;
            wr_code_q <= wr_code_d;
            hrdata_q <= hrdata_d;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
            ctrl_q <= ctrl_d;
            code_q <= code_d;
        end
    end

    assign hreadyout = hready_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;

    // ------------------------------------------------------------------
    // power sequencing and conversion start
    // ------------------------------------------------------------------
    dcl_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    dcl_analog_t analog_q, analog_d;
    logic busy_q, busy_d;
    logic halted;
    logic want;
    logic start;

    // debug halt ignored
    // no debug-halt input on purpose: a halted cpu leaves this logic running
    always_comb
    begin
        halted = powerdown_sleep || (standby_sleep && !ctrl_q.keep_running);
        want = ctrl_q.enable && !halted;
        state_d = state_q;
        cnt_d = cnt_q;
        start = 1'b0;
        unique case (state_q)
            DCL_ST_OFF:
            begin
                // power-up always passes the start-up time
                if (want)
                begin
                    state_d = DCL_ST_WARM;
                    cnt_d = DCL_STARTUP_LOAD;
                end
            end
            DCL_ST_WARM:
            begin
                if (!want)
                    state_d = DCL_ST_OFF;
                else if (cnt_q == 8'h00)
                begin
                    state_d = DCL_ST_RUN;
                    start = 1'b1;
                end
                else
                    cnt_d = cnt_q - 8'h01;
            end
            DCL_ST_RUN:
            begin
                if (!want)
                    state_d = DCL_ST_OFF;
                // write while running converts at once
                else if (wr_code_q)
                    start = 1'b1;
            end
        endcase
        analog_d = analog_q;
        analog_d.start = start;
        if (start)
            analog_d.code = code_d;
        analog_d.powered = (state_d != DCL_ST_OFF);
        // internal consumers see output whenever running
        analog_d.internal_avail = (state_d == DCL_ST_RUN);
        // pin buffer only on the first instance
        analog_d.buffer_on = (state_d != DCL_ST_OFF) &&
            ctrl_q.pin_buffer_on && (INSTANCE_NUM == 0);
        busy_d = (state_d == DCL_ST_WARM);
    end

    // registers of the sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= DCL_ST_OFF;
            cnt_q <= 8'h00;
            analog_q <= '0;
            busy_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            analog_q <= analog_d;
            busy_q <= busy_d;
        end
    end

    assign analog = analog_q;
    assign startup_busy = busy_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking dcl_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // low byte of write data as a plain signal for the $past checks
    logic [7:0] wr_byte;
    assign wr_byte = hwdata[7:0];

    a_ctrl_write_mask: assert property (
        ce && wr_ctrl_q |=>
            ctrl_q == dcl_ctrl_t'($past(wr_byte) & DCL_CTRL_WMASK))
        else $error("control write not masked");

    a_enable_off: assert property (
        ce && !ctrl_q.enable |=> !analog_q.powered && !analog_q.start)
        else $error("converter on while disabled");

    a_enable_on: assert property (
        ce && want && state_q == DCL_ST_OFF |=>
            analog_q.powered && startup_busy && !analog_q.start)
        else $error("enable did not begin power-up");

    // write while running starts conversion of that value
    a_write_starts: assert property (
        ce && want && state_q == DCL_ST_RUN && wr_code_q |=>
            analog_q.start && analog_q.code == $past(wr_byte))
        else $error("running write did not start conversion");

    a_write_stores: assert property (
        ce && wr_code_q && !ctrl_q.enable |=>
            !analog_q.start && code_q == $past(wr_byte))
        else $error("disabled write misbehaved");

    a_internal_avail: assert property (
        ce && want && state_q == DCL_ST_RUN |=> analog_q.internal_avail)
        else $error("running output not offered internally");

    // buffer follows bit 6 on the first instance only
    a_buffer_route: assert property (
        ce && want && state_q != DCL_ST_OFF |=>
            analog_q.buffer_on == ($past(ctrl_q.pin_buffer_on) &&
            (INSTANCE_NUM == 0)))
        else $error("pin buffer routing wrong");

    a_standby_keep: assert property (
        ce && standby_sleep && !powerdown_sleep && ctrl_q.keep_running &&
        ctrl_q.enable && state_q == DCL_ST_RUN |=> analog_q.internal_avail)
        else $error("converter stopped in standby");

    a_sleep_off: assert property (
        ce && halted |=> !analog_q.powered && !analog_q.buffer_on)
        else $error("converter on during shutdown sleep");

    // warm-up ends in a conversion after its count
    a_startup_end: assert property (
        ce && want && state_q == DCL_ST_WARM && cnt_q == 8'h00 |=>
            analog_q.start && !startup_busy)
        else $error("start-up did not end in conversion");

    // held code is the one converted at warm-up end
    a_held_code: assert property (
        ce && want && state_q == DCL_ST_WARM && cnt_q == 8'h00 |=>
            analog_q.code == $past(code_d))
        else $error("warm-up end converted wrong code");

    // later instances never drive the pin
    a_pin_first: assert property (
        analog_q.buffer_on |-> INSTANCE_NUM == 0 && analog_q.powered)
        else $error("pin buffer on illegal instance");

endmodule

// ### design/dcl_pkg.sv
// constants, field layouts and carrier types of the converter control block
// assumes a single 20 MHz peripheral clock and an AHB-Lite register bus

package dcl_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    // printed offsets are register indices; byte address is index times 4
    localparam logic [5:0] DCL_CTRL_IDX = 6'h00;
    localparam logic [5:0] DCL_CODE_IDX = 6'h01;
    localparam logic [7:0] DCL_CTRL_RST = 8'h00;
    localparam logic [7:0] DCL_CODE_RST = 8'h00;
    // only keep-running, pin buffer and enable are writable
    localparam logic [7:0] DCL_CTRL_WMASK = 8'hC1;
    localparam logic [2:0] DCL_HSIZE_WORD = 3'h2;
    localparam logic [1:0] DCL_HTRANS_NONSEQ = 2'h2;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned DCL_CLK_PERIOD_NS = 50;
    localparam int unsigned DCL_STARTUP_NS = 1000;
    // least time, so round up to whole cycles
    localparam int unsigned DCL_STARTUP_CYC_RAW =
        (DCL_STARTUP_NS + DCL_CLK_PERIOD_NS - 1) / DCL_CLK_PERIOD_NS;
    localparam int unsigned DCL_STARTUP_CYC =
        (DCL_STARTUP_CYC_RAW < 1) ? 1 : DCL_STARTUP_CYC_RAW;
    localparam logic [7:0] DCL_STARTUP_LOAD = 8'(DCL_STARTUP_CYC - 1);

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    // control register layout, msb first
    typedef struct packed {
        logic keep_running;
        logic pin_buffer_on;
        logic [4:0] unused;
        logic enable;
    } dcl_ctrl_t;

    // signals handed to the analog string, driver and internal consumers
    typedef struct packed {
        logic powered;
        logic internal_avail;
        logic buffer_on;
        logic start;
        logic [7:0] code;
    } dcl_analog_t;

    typedef enum logic [2:0] {
        DCL_ST_OFF = 3'b001,
        DCL_ST_WARM = 3'b010,
        DCL_ST_RUN = 3'b100
    } dcl_state_t;

endpackage

// ### test/dcl_consumer_model.sv
// model of the comparator and sampler behind the converter
// assumes the analog carrier is registered on hclk
`timescale 1ns/1ps

module dcl_consumer_model
    import dcl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire dcl_analog_t analog,
    output int n_starts,
    output logic [7:0] last_code
);
    // ----------------------------------------------------------------
    // conversion capture
    // ----------------------------------------------------------------
    // take a code only when offered internally
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            n_starts <= 0;
            last_code <= 8'h00;
        end
        else if (analog.start && analog.internal_avail)
        begin
            n_starts <= n_starts + 1;
            last_code <= analog.code;
        end
    end
endmodule

// ### test/dcl_dac_control_tb.sv
// bench for the converter control block: bus, sleep and start checks
// assumes a zero-wait slave and a 20 MHz clock
`timescale 1ns/1ps

module dcl_dac_control_tb
    import dcl_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b1;
    logic hwrite = 1'b0;
    logic stby = 1'b0;
    logic pdown = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = DCL_HSIZE_WORD;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hready, hresp, busy;
    logic [31:0] hrdata;
    logic [7:0] last, v;
    dcl_analog_t ana, ana2;
    int fails = 0;
    int n_checks = 0;
    int starts, ns;

    dcl_dac_control dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .standby_sleep(stby), .powerdown_sleep(pdown), .analog(ana),
        .startup_busy(busy));
    // a second instance shares the bus but has no pin path
    dcl_dac_control #(.INSTANCE_NUM(1)) dut2_u (.hclk(hclk),
        .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(), .hresp(), .hrdata(),
        .standby_sleep(stby), .powerdown_sleep(pdown), .analog(ana2),
        .startup_busy());
    dcl_consumer_model model_u (.hclk(hclk), .hresetn(hresetn),
        .analog(ana), .n_starts(starts), .last_code(last));

    // 50 ns period
    initial
    begin
        forever #25 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    function automatic logic [7:0] ctrl_rb(input logic [7:0] d);
        return d & DCL_CTRL_WMASK;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_rdy();
        for (int i = 0; i < 16; i++)
        begin
            @(posedge hclk);
            if (hready === 1'b1)
                return;
        end
        fails++;
        $display("Error at %0t: no hready", $time);
        tally_and_finish();
    endtask

    task automatic xfer(input logic w, input logic [5:0] idx,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        haddr <= {24'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= DCL_HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] x;
        xfer(1'b1, idx, {24'h0, d}, x);
    endtask

    task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
        logic [31:0] x;
        xfer(1'b0, idx, 32'h0, x);
        chk(x, {24'h0, e});
        chk(32'(hresp), 32'h0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge hclk);
    endtask

    // start count must reach n within lim cycles
    task automatic wait_start(input int n, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(negedge hclk);
            if (starts == n)
                return;
        end
        fails++;
        $display("Error at %0t: start count %0d", $time, starts);
        tally_and_finish();
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(80092));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(DCL_CTRL_IDX, DCL_CTRL_RST);
        rchk(DCL_CODE_IDX, DCL_CODE_RST);
        rchk(6'h02, 8'h00);
        $display("test reset done");
        // code first, then enable, as software is told to
        v = 8'($urandom);
        wr(DCL_CODE_IDX, v);
        rchk(DCL_CODE_IDX, v);
        wr(DCL_CTRL_IDX, 8'h41);
        tick(DCL_STARTUP_CYC - 2);
        chk(32'({starts == 0, busy, ana.powered}), 32'h7);
        wait_start(1, 8);
        chk(32'({last, ana.internal_avail, ana.buffer_on}),
            32'({v, 2'b11}));
        chk(32'(ana2.buffer_on), 32'h0);
        $display("test enable done");
        // random codes with both extremes convert at once
        for (int k = 0; k < 6; k++)
        begin
            v = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
            wr(DCL_CODE_IDX, v);
            wait_start(k + 2, 3);
            chk(32'(last), 32'(v));
        end
        ns = starts;
        wr(DCL_CTRL_IDX, 8'hFF);
        rchk(DCL_CTRL_IDX, ctrl_rb(8'hFF));
        $display("test codes done");
        // standby with and without keep-running
        stby <= 1'b1;
        tick(4);
        chk(32'({ana.powered, ana.buffer_on}), 32'h3);
        wr(DCL_CTRL_IDX, 8'h41);
        wr(DCL_CODE_IDX, 8'h5A);
        tick(2);
        chk(32'({ana.powered, ana.buffer_on, ana.internal_avail}), 0);
        chk(starts, ns);
        @(posedge hclk);
        stby <= 1'b0;
        tick(DCL_STARTUP_CYC - 2);
        chk(32'({starts == ns, busy}), 32'h3);
        wait_start(ns + 1, 8);
        chk(32'({last, ana.buffer_on}), 32'({8'h5A, 1'b1}));
        $display("test standby done");
        // power-down ignores keep-running; buffer off without bit 6
        wr(DCL_CTRL_IDX, 8'h81);
        tick(2);
        chk(32'({ana.powered, ana.buffer_on}), 32'h2);
        @(posedge hclk);
        pdown <= 1'b1;
        tick(3);
        chk(32'({ana.powered, ana.internal_avail}), 32'h0);
        @(posedge hclk);
        pdown <= 1'b0;
        wait_start(ns + 2, DCL_STARTUP_CYC + 6);
        wr(DCL_CTRL_IDX, 8'h00);
        tick(2);
        chk(32'({ana.powered, ana.internal_avail}), 32'h0);
        $display("test power-down done");
        // a low clock enable freezes the start-up count at its load value
        wr(DCL_CTRL_IDX, 8'h01);
        @(posedge hclk);
        ce <= 1'b0;
        tick(30);
        chk(32'({busy, ana.powered, starts == ns + 2}), 32'h7);
        @(posedge hclk);
        ce <= 1'b1;
        wait_start(ns + 3, DCL_STARTUP_CYC + 8);
        $display("test clock enable done");
        tally_and_finish();
    end
endmodule
